// [rtl/psl_strap_bank.sv]
// Strap, lane mapping and de-emphasis configuration bank with an APB slave.
`timescale 1ns/1ns
// Function
// [R1] One role bit per port group: 0 downstream, 1 upstream component.
// [R2] Six PHY lanes each have shift-by-one and shift-by-two transmit bits.
// [R3] Eight logic lanes each have a 2-bit receive source select field.
// [R4] Per-core active-low strap load bit; 0 lets straps load into core.
// [R5] Whole-core reversal on 16-lane cores mirrors lanes 0 and 15.
// [R6] Whole-core reversal on the six-lane core mirrors lanes 0 and 5.
// [R7] One PHY lane reversal bit per port, default off.
// [R8] One link controller lane reversal bit per port, default off.
// [R9] One clock force-off bit per core stops that core's link clock.
// [R10] Three-bit select makes alternate strength override strap strength.
// [R11] Per-port bit sets advertised de-emphasis default, 1 is -3.5dB.
// [R12] Per-port source bit: 1 core training logic chooses, 0 strap strength.
// [R13] Fields reset to defaults, read back writes, drive outputs directly.
module psl_strap_bank
  import psl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [2:0] o_port_role,
  output logic [5:0] o_tx_lane_shift_one,
  output logic [5:0] o_tx_lane_shift_two,
  output logic [15:0] o_rx_lane_source_select,
  output logic [3:0] o_strap_load_n,
  output logic [2:0] o_core_lane_reverse_all,
  output logic [9:0] o_phy_port_lane_reverse,
  output logic [9:0] o_linkctl_port_lane_reverse,
  output logic [3:0] o_core_clock_force_off,
  output logic [2:0] o_alt_deemph_priority_sel,
  output logic [9:0] o_advertised_deemph_default,
  output logic [9:0] o_core_deemph_source_sel,
  input wire logic [11:0] i_logical_lane,
  output logic [11:0] o_mirrored_lane
);

  logic [31:0] role_r;
  logic [31:0] mux_r;
  logic [31:0] rev_r;
  logic [31:0] deemph_r;
  logic [31:0] prdata_r;
  logic err_r;
  logic cap_r;
  logic [31:0] byte_mask;
  logic [31:0] rd_nxt;
  logic hit;
  logic wr_go;
  logic wr_role;
  logic wr_mux;
  logic wr_rev;
  logic wr_deemph;

  // Byte enables widen to a bit mask, one lane of eight bits per strobe.
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_byte
      assign byte_mask[8*gb +: 8] = {8{i_pstrb[gb]}};
    end
  endgenerate

  // A write lands only at the completing edge of the access phase.
  assign wr_go = i_ce && i_psel && i_penable && cap_r && i_pwrite;
  assign wr_role = wr_go && (i_paddr == ADDR_ROLE);
  assign wr_mux = wr_go && (i_paddr == ADDR_MUX);
  assign wr_rev = wr_go && (i_paddr == ADDR_REV);
  assign wr_deemph = wr_go && (i_paddr == ADDR_DEEMPH);

  // Read decode; reserved bits come back as zero through the masks.
  always_comb begin
    hit = 1'b1;
    case (i_paddr)
      ADDR_ROLE: rd_nxt = role_r & MASK_ROLE;
      ADDR_MUX: rd_nxt = mux_r & MASK_MUX;
      ADDR_REV: rd_nxt = rev_r & MASK_REV;
      ADDR_DEEMPH: rd_nxt = deemph_r & MASK_DEEMPH;
      default: begin
        rd_nxt = 32'h0000_0000;
        hit = 1'b0;
      end
    endcase
  end

  // Role straps, one per port group.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      role_r <= RST_ROLE;
    end else if (wr_role) begin
      role_r <= (role_r & ~(byte_mask & MASK_ROLE)) | (i_pwdata & byte_mask & MASK_ROLE); // see [R1] see [R13]
    end
  end

  // Lane mux settings and strap load strobes.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mux_r <= RST_MUX; // see [R2] see [R3]
    end else if (wr_mux) begin
      mux_r <= (mux_r & ~(byte_mask & MASK_MUX)) | (i_pwdata & byte_mask & MASK_MUX); // see [R4] see [R13]
    end
  end

  // Lane reversal, clock gating and alternate de-emphasis priority.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rev_r <= RST_REV; // see [R7] see [R8] see [R9]
    end else if (wr_rev) begin
      rev_r <= (rev_r & ~(byte_mask & MASK_REV)) | (i_pwdata & byte_mask & MASK_REV); // see [R10] see [R13]
    end
  end

  // Advertised de-emphasis defaults and de-emphasis source selects.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      deemph_r <= RST_DEEMPH; // see [R11] see [R12]
    end else if (wr_deemph) begin
      deemph_r <= (deemph_r & ~(byte_mask & MASK_DEEMPH)) | (i_pwdata & byte_mask & MASK_DEEMPH); // see [R13]
    end
  end

  // Read data is captured one edge before pready, so the data output comes
  // from a flip-flop at the cost of a mandatory setup edge with i_ce high.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
      cap_r <= 1'b0;
    end else if (i_ce) begin
      cap_r <= i_psel && !(i_penable && cap_r);
      if (i_psel) begin
        prdata_r <= i_pwrite ? 32'h0000_0000 : rd_nxt; // see [R13]
        err_r <= !hit;
      end
    end
  end

  // The answer is held off while the clock enable is low.
  assign o_pready = i_ce && cap_r;
  assign o_prdata = prdata_r;
  assign o_pslverr = o_pready && i_psel && i_penable && err_r;

  // Configuration outputs follow the stored bits directly.
  assign o_port_role = role_r[ROLE_LSB +: ROLE_W]; // see [R1]
  assign o_strap_load_n = mux_r[LOAD_LSB +: CORES]; // see [R4]
  assign o_core_lane_reverse_all = rev_r[REV_ALL_LSB +: REV_CORES];
  assign o_phy_port_lane_reverse = rev_r[PHY_REV_LSB +: PORTS]; // see [R7]
  assign o_linkctl_port_lane_reverse = rev_r[LC_REV_LSB +: PORTS]; // see [R8]
  assign o_core_clock_force_off = rev_r[CLK_OFF_LSB +: CORES]; // see [R9]
  assign o_alt_deemph_priority_sel = rev_r[ALT_SEL_LSB +: ALT_SEL_W]; // see [R10]
  assign o_core_deemph_source_sel = deemph_r[SRC_LSB +: PORTS]; // see [R12]

  // The wide group's two ports sit at the top of one register, the rest below.
  assign o_advertised_deemph_default = {deemph_r[ADV_LO_LSB +: ADV_LO_W], rev_r[ADV_HI_LSB +: ADV_HI_W]}; // see [R11]

  // Transmit shift pairs interleave per PHY lane.
  genvar gt;
  generate
    for (gt = 0; gt < TX_LANES; gt++) begin : g_tx
      assign o_tx_lane_shift_one[gt] = mux_r[2*gt]; // see [R2]
      assign o_tx_lane_shift_two[gt] = mux_r[2*gt+1]; // see [R2]
    end
  endgenerate

  // Receive select fields, one per logic lane.
  genvar gr;
  generate
    for (gr = 0; gr < RX_LANES; gr++) begin : g_rx
      assign o_rx_lane_source_select[RX_SEL_W*gr +: RX_SEL_W] = mux_r[RX_SEL_LSB+RX_SEL_W*gr +: RX_SEL_W]; // see [R3]
    end
  endgenerate

  // Whole-core reversal acts alone; per-port bits do not enter the mirror.
  genvar gm;
  generate
    for (gm = 0; gm < REV_CORES; gm++) begin : g_mirror
      psl_lane_mirror #(
        .LANES((gm == REV_CORES - 1) ? NARROW_LANES : WIDE_LANES)
      ) u_mirror (
        .i_reverse(rev_r[REV_ALL_LSB + gm]), // see [R5] see [R6]
        .i_lane(i_logical_lane[LANE_W*gm +: LANE_W]),
        .o_lane(o_mirrored_lane[LANE_W*gm +: LANE_W])
      );
    end
  endgenerate

  // Checks on the bus and on the outputs.
  sequence s_setup_rd(logic [11:0] a);
    i_psel && !i_penable && !i_pwrite && (i_paddr == a) && i_ce;
  endsequence

  sequence s_full_wr(logic [11:0] a);
    wr_go && (i_paddr == a) && (i_pstrb == 4'hF);
  endsequence

  AST_ROLE_WRITE: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [R1]
    s_full_wr(ADDR_ROLE) |=> (o_port_role == $past(i_pwdata[29:27])))
    else $error("role bits did not follow the write");

  AST_TX_SHIFT: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [R2]
    s_full_wr(ADDR_MUX) |=> (o_tx_lane_shift_one[5] == $past(i_pwdata[10])) && (o_tx_lane_shift_two[0] == $past(i_pwdata[1])))
    else $error("transmit shift bits mismatch");

  AST_RX_SELECT: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [R3]
    s_full_wr(ADDR_MUX) |=> (o_rx_lane_source_select == $past(i_pwdata[27:12])))
    else $error("receive select fields mismatch");

  AST_STRAP_LOAD: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [R4]
    s_full_wr(ADDR_MUX) |=> (o_strap_load_n == $past(i_pwdata[31:28])))
    else $error("strap load strobes mismatch");

  AST_MIRROR_WIDE: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [R5]
    (o_core_lane_reverse_all[0] && (i_logical_lane[3:0] == 4'h0)) |-> (o_mirrored_lane[3:0] == 4'hF))
    else $error("wide core lane 0 not mirrored to 15");

  AST_MIRROR_NARROW: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [R6]
    (o_core_lane_reverse_all[2] && (i_logical_lane[11:8] == 4'h5)) |-> (o_mirrored_lane[11:8] == 4'h0))
    else $error("narrow core lane 5 not mirrored to 0");

  AST_PHY_REV_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [R7]
    !wr_rev |=> $stable(o_phy_port_lane_reverse))
    else $error("phy reversal changed without a write");

  AST_LC_REV: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [R8]
    s_full_wr(ADDR_REV) |=> (o_linkctl_port_lane_reverse == $past(i_pwdata[22:13])))
    else $error("link controller reversal mismatch");

  AST_CLOCK_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [R9]
    (s_full_wr(ADDR_REV) && i_pwdata[26]) |=> o_core_clock_force_off[3])
    else $error("clock force-off did not take");

  AST_ALT_SEL: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [R10]
    s_full_wr(ADDR_REV) |=> (o_alt_deemph_priority_sel == $past(i_pwdata[29:27])))
    else $error("alternate priority select mismatch");

  AST_ADV_DEFAULT: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [R11]
    s_full_wr(ADDR_DEEMPH) |=> (o_advertised_deemph_default[9:2] == $past(i_pwdata[7:0])))
    else $error("advertised de-emphasis default mismatch");

  AST_SRC_SEL: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [R12]
    s_full_wr(ADDR_DEEMPH) |=> (o_core_deemph_source_sel == $past(i_pwdata[17:8])))
    else $error("de-emphasis source select mismatch");

  AST_READBACK: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see [R13]
    s_setup_rd(ADDR_MUX) ##1 (i_psel && i_penable && o_pready) |-> (o_prdata == mux_r))
    else $error("read data differs from stored lane mux word");

endmodule : psl_strap_bank

// [rtl/psl_pkg.sv]
// Package with register map, field layout and reset values of the strap and lane configuration bank.
package psl_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_ROLE = 8'h25;
  localparam logic [7:0] IDX_MUX = 8'h26;
  localparam logic [7:0] IDX_REV = 8'h27;
  localparam logic [7:0] IDX_DEEMPH = 8'h28;
  localparam logic [11:0] ADDR_ROLE = {2'b00, IDX_ROLE, 2'b00};
  localparam logic [11:0] ADDR_MUX = {2'b00, IDX_MUX, 2'b00};
  localparam logic [11:0] ADDR_REV = {2'b00, IDX_REV, 2'b00};
  localparam logic [11:0] ADDR_DEEMPH = {2'b00, IDX_DEEMPH, 2'b00};

  // Implemented bits of each register; all other bits read as zero.
  localparam logic [31:0] MASK_ROLE = 32'h3800_0000;
  localparam logic [31:0] MASK_MUX = 32'hFFFF_FFFF;
  localparam logic [31:0] MASK_REV = 32'hFFFF_FFFF;
  localparam logic [31:0] MASK_DEEMPH = 32'h0003_FFFF;

  // Reset values.
  localparam logic [31:0] RST_ROLE = 32'h0000_0000;
  localparam logic [31:0] RST_MUX = 32'h02AA_3554;
  localparam logic [31:0] RST_REV = 32'hC000_0000;
  localparam logic [31:0] RST_DEEMPH = 32'h0003_FF7F;

  // Field positions in the role register.
  localparam int ROLE_LSB = 27;
  localparam int ROLE_W = 3;

  // Field positions in the lane mux register.
  localparam int TX_LANES = 6;
  localparam int RX_LANES = 8;
  localparam int RX_SEL_LSB = 12;
  localparam int RX_SEL_W = 2;
  localparam int LOAD_LSB = 28;
  localparam int CORES = 4;

  // Field positions in the lane reverse and clock gate register.
  localparam int REV_ALL_LSB = 0;
  localparam int REV_CORES = 3;
  localparam int PHY_REV_LSB = 3;
  localparam int PORTS = 10;
  localparam int LC_REV_LSB = 13;
  localparam int CLK_OFF_LSB = 23;
  localparam int ALT_SEL_LSB = 27;
  localparam int ALT_SEL_W = 3;
  localparam int ADV_HI_LSB = 30;
  localparam int ADV_HI_W = 2;

  // Field positions in the de-emphasis default register.
  localparam int ADV_LO_LSB = 0;
  localparam int ADV_LO_W = 8;
  localparam int SRC_LSB = 8;

  // Lane counts of the wide cores and of the narrow core.
  localparam int WIDE_LANES = 16;
  localparam int NARROW_LANES = 6;
  localparam int LANE_W = 4;

endpackage : psl_pkg

// [rtl/psl_lane_mirror.sv]
// Lane number mirror for one core, used for whole-core lane reversal.
`timescale 1ns/1ns
module psl_lane_mirror #(
  parameter int LANES = 16
) (
  input wire logic i_reverse,
  input wire logic [3:0] i_lane,
  output logic [3:0] o_lane
);

  localparam logic [3:0] TOP_LANE = 4'(LANES - 1);

  // Lane numbers beyond the core width pass unchanged, since they do not exist.
  always_comb begin
    if (i_reverse && (i_lane <= TOP_LANE)) begin
      o_lane = TOP_LANE - i_lane;
    end else begin
      o_lane = i_lane;
    end
  end

endmodule : psl_lane_mirror

// [verif/psl_core_model.sv]
// Behavioural model of the port cores that take their role straps while the load strobe is low.
`timescale 1ns/1ns
module psl_core_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_strap_load_n,
  input wire logic [2:0] i_port_role,
  output logic [2:0] o_core_role
);
  // A high strobe keeps the old strap, so late register writes do not disturb a running core.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_core_role <= 3'b000;
    end else begin
      for (int k = 0; k < 3; k++) begin
        if (!i_strap_load_n[k]) begin
          o_core_role[k] <= i_port_role[k];
        end
      end
    end
  end
endmodule : psl_core_model

// [verif/tb.sv]
// Self-checking testbench of the strap and lane configuration bank.
`timescale 1ns/1ns
module tb;
  import psl_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, lane, mir;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, load_n, clk_off;
  logic [2:0] role, rev_all, alt_sel, core_role;
  logic [5:0] sh1, sh2;
  logic [15:0] rx_sel;
  logic [9:0] phy_rev, lc_rev, adv, src;
  logic err;
  logic ce;
  int n_mismatch, check_count, cyc;

  psl_strap_bank i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_port_role(role), .o_tx_lane_shift_one(sh1),
    .o_tx_lane_shift_two(sh2), .o_rx_lane_source_select(rx_sel), .o_strap_load_n(load_n),
    .o_core_lane_reverse_all(rev_all), .o_phy_port_lane_reverse(phy_rev),
    .o_linkctl_port_lane_reverse(lc_rev), .o_core_clock_force_off(clk_off),
    .o_alt_deemph_priority_sel(alt_sel), .o_advertised_deemph_default(adv),
    .o_core_deemph_source_sel(src), .i_logical_lane(lane), .o_mirrored_lane(mir));

  psl_core_model i_core (.i_clk(clk), .i_rst_n(rst_n), .i_strap_load_n(load_n), .i_port_role(role),
    .o_core_role(core_role));

  // Free-running bus clock of 50 ns.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    $display("Mismatches %0d of %0d checks", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  // One APB transfer; pready, read data and error are all taken at the completing rising edge.
  // The short wait at the end lets the written register settle before the caller looks at outputs.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    check(nm, rd, exp);
  endtask : rd_chk

  task automatic t_reset;
    rd_chk("role", ADDR_ROLE, 32'h0000_0000);
    rd_chk("mux", ADDR_MUX, 32'h02AA_3554);
    rd_chk("rev", ADDR_REV, 32'hC000_0000);
    rd_chk("deemph", ADDR_DEEMPH, 32'h0003_FF7F);
    check("shift1", sh1, 6'b11_1110);
    check("shift2", sh2, 6'b00_0000);
    check("rxsel", rx_sel, {2'd0, {5{2'd2}}, 2'd0, 2'd3});
    check("adv0", adv, 10'h1FF);
    check("src0", src, 10'h3FF);
  endtask : t_reset

  task automatic t_reverse;
    apb(1'b1, ADDR_REV, 32'hFFFF_FFFF, 4'b0001);
    rd_chk("revb", ADDR_REV, 32'hC000_00FF);
    check("revall", rev_all, 3'b111);
    check("phyrev", phy_rev, 10'h01F);
    @(posedge clk);
    lane <= 12'h5F0;
    #1;
    check("mirror", mir, 12'h00F);
    apb(1'b1, ADDR_REV, 32'h3F80_0000, 4'hF);
    check("clkoff", clk_off, 4'hF);
    check("altsel", alt_sel, 3'h7);
    check("lcrev", lc_rev, 10'h000);
    check("mirror2", mir, 12'h5F0);
    apb(1'b1, ADDR_REV, 32'h007F_E000, 4'hF);
    check("lcrev2", lc_rev, 10'h3FF);
    apb(1'b1, ADDR_DEEMPH, 32'h0000_0080, 4'hF);
    check("adv", adv, 10'h200);
    check("src", src, 10'h000);
  endtask : t_reverse

  task automatic t_role_load;
    apb(1'b1, ADDR_MUX, 32'hF2AA_3554, 4'hF);
    check("loadn", load_n, 4'hF);
    apb(1'b1, ADDR_ROLE, 32'hFFFF_FFFF, 4'hF);
    rd_chk("role1", ADDR_ROLE, 32'h3800_0000);
    check("role", role, 3'b111);
    repeat (2) @(posedge clk);
    check("held", core_role, 3'b000);
    apb(1'b1, ADDR_MUX, 32'hE2AA_3554, 4'b1000);
    repeat (2) @(posedge clk);
    check("loaded", core_role, 3'b001);
    apb(1'b1, 12'h0F0, 32'hFFFF_FFFF, 4'hF);
    check("errw", err, 1'b1);
    rd_chk("unmap", 12'h0F0, 32'h0000_0000);
  endtask : t_role_load

  // A low clock enable must hold off the answer and the write until it returns.
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    fork
      apb(1'b1, ADDR_ROLE, 32'h0000_0000, 4'hF);
      begin
        repeat (4) @(posedge clk);
        check("frz_rdy", pready, 1'b0);
        check("frz_role", role, 3'b111);
        ce <= 1'b1;
      end
    join
    check("thaw_role", role, 3'b000);
  endtask : t_freeze

  // Cuts a hung run short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    {rst_n, psel, penable, pwrite} = 4'b0000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    lane = 12'h000;
    ce = 1'b1;
    cyc = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_reverse();
    t_role_load();
    t_freeze();
    stop_test();
  end
endmodule : tb
